// [logic/psm_pkg.sv]
// shared constants and types for the power saving mode control block
package psm_pkg;

  // power control register field positions
  localparam int PSM_DOZE_ARM_POS = 0;
  localparam int PSM_SLEEP_ARM_POS = 1;
  localparam int PSM_GF0_POS = 2;
  localparam int PSM_GF1_POS = 3;
  localparam int PSM_DOZE_START_POS = 5;
  localparam int PSM_SLEEP_START_POS = 6;
  localparam int PSM_BAUD_DBL_POS = 7;
  localparam logic [7:0] PSM_CTL_RESET = 8'h00;

  // host register offsets
  localparam logic [3:0] PSM_OFS_RAW = 4'h0;
  localparam logic [3:0] PSM_OFS_CMD = 4'h1;
  localparam logic [3:0] PSM_OFS_STATUS = 4'h2;
  localparam logic [3:0] PSM_OFS_LAST = 4'h3;

  // host command and status bit positions
  localparam int PSM_CMD_DOZE_POS = 0;
  localparam int PSM_CMD_SLEEP_POS = 1;
  localparam int PSM_ST_BUSY_POS = 0;
  localparam int PSM_ST_DOZE_POS = 1;
  localparam int PSM_ST_SLEEP_POS = 2;

  typedef enum logic [2:0] {
    PSM_RUN = 3'b001,
    PSM_DOZE = 3'b010,
    PSM_SLEEP = 3'b100
  } psm_mode_t;

  typedef enum logic [3:0] {
    PSM_H_IDLE = 4'b0001,
    PSM_H_READ = 4'b0010,
    PSM_H_ARM = 4'b0100,
    PSM_H_START = 4'b1000
  } psm_hstate_t;

endpackage

// [logic/psm_link_if.sv]
// link between the cpu side and the power control register
`timescale 1ns/1ps
interface psm_link_if;
  logic ctl_wr;
  logic ctl_rd;
  logic [7:0] ctl_wdata;
  logic [7:0] ctl_rdata;
  logic in_doze;
  logic in_sleep;

  modport dev (
    input ctl_wr,
    input ctl_rd,
    input ctl_wdata,
    output ctl_rdata,
    output in_doze,
    output in_sleep
  );

  modport host (
    output ctl_wr,
    output ctl_rd,
    output ctl_wdata,
    input ctl_rdata,
    input in_doze,
    input in_sleep
  );
endinterface

// [logic/psm_dev.sv]
// power control register and doze / sleep sequencer
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps

module psm_dev
  import psm_pkg::*;
#(
  parameter int PORT_W = 8,
  parameter int ALT_W = 8
) (
  input wire logic MCLK,
  input wire logic RESET_N,
  psm_link_if.dev link,
  input wire logic IRQ_PENDING,
  input wire logic ALE_IN,
  input wire logic FETCH_STROBE_IN,
  input wire logic [ALT_W-1:0] ALT_IN,
  input wire logic [PORT_W-1:0] PORT_PIN,
  output logic [PORT_W-1:0] PORT_SEEN,
  output logic [ALT_W-1:0] ALT_OUT,
  output logic ALE,
  output logic PROGRAM_FETCH_STROBE,
  output logic CPU_CLK_EN,
  output logic PERIPH_CLK_EN,
  output logic WDT_RUN,
  output logic OSC_RUN,
  output logic BAUD_DOUBLE,
  output logic [1:0] GEN_FLAGS
);

  typedef struct packed {
    psm_mode_t mode;
    logic doze_armed;
    logic sleep_armed;
    logic baud_dbl;
    logic [1:0] gen_flags;
    logic [7:0] rdata;
    logic [PORT_W-1:0] pin_meta;
    logic [PORT_W-1:0] pin_sync;
    logic [PORT_W-1:0] port_seen;
    logic [ALT_W-1:0] alt_out;
    logic ale;
    logic fetch_strobe;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic wdt_run;
    logic osc_run;
  } psm_dev_state_t;

  localparam psm_dev_state_t RESET_STATE = '{
    mode: PSM_RUN,
    doze_armed: 1'b0,
    sleep_armed: 1'b0,
    baud_dbl: PSM_CTL_RESET[PSM_BAUD_DBL_POS],
    gen_flags: PSM_CTL_RESET[PSM_GF1_POS:PSM_GF0_POS],
    rdata: 8'h00,
    pin_meta: '0,
    pin_sync: '0,
    port_seen: '0,
    alt_out: '0,
    ale: 1'b1,
    fetch_strobe: 1'b1,
    cpu_clk_en: 1'b1,
    periph_clk_en: 1'b1,
    wdt_run: 1'b1,
    osc_run: 1'b1
  };

  psm_dev_state_t s;
  psm_dev_state_t next_s;

  logic wr_doze_arm;
  logic wr_doze_start;
  logic wr_sleep_arm;
  logic wr_sleep_start;
  logic go_doze;
  logic go_sleep;
  logic [7:0] ctl_view;

  ////////////////////////////////////////////////////////////////////////////////
  // write decode

  assign wr_doze_arm = link.ctl_wdata[PSM_DOZE_ARM_POS];
  assign wr_doze_start = link.ctl_wdata[PSM_DOZE_START_POS];
  assign wr_sleep_arm = link.ctl_wdata[PSM_SLEEP_ARM_POS];
  assign wr_sleep_start = link.ctl_wdata[PSM_SLEEP_START_POS];

  assign go_doze = link.ctl_wr && s.doze_armed && wr_doze_start && !wr_doze_arm;
  assign go_sleep = link.ctl_wr && s.sleep_armed && wr_sleep_start && !wr_sleep_arm;

  always_comb begin
    ctl_view = 8'h00;
    ctl_view[PSM_BAUD_DBL_POS] = s.baud_dbl;
    ctl_view[PSM_GF1_POS] = s.gen_flags[1];
    ctl_view[PSM_GF0_POS] = s.gen_flags[0];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_s = s;
    next_s.rdata = link.ctl_rd ? ctl_view : 8'h00;
    case (s.mode)
      PSM_RUN: begin
        if (link.ctl_wr) begin
          next_s.baud_dbl = link.ctl_wdata[PSM_BAUD_DBL_POS];
          next_s.gen_flags = link.ctl_wdata[PSM_GF1_POS:PSM_GF0_POS];
          next_s.doze_armed = wr_doze_arm && !wr_doze_start;
          next_s.sleep_armed = wr_sleep_arm && !wr_sleep_start;
          if (go_sleep) begin
            next_s.mode = PSM_SLEEP;
          end else if (go_doze) begin
            next_s.mode = PSM_DOZE;
          end
        end
      end
      PSM_DOZE: begin
        if (IRQ_PENDING) begin
          next_s.mode = PSM_RUN;
        end
      end
      PSM_SLEEP: begin
        next_s.mode = PSM_SLEEP;
      end
      default: begin
        next_s.mode = PSM_RUN;
      end
    endcase

    // pin inputs kept alive outside sleep
    if (s.mode != PSM_SLEEP) begin
      next_s.pin_meta = PORT_PIN;
      next_s.pin_sync = s.pin_meta;
      next_s.port_seen = s.pin_sync;
    end

    // alternate outputs frozen at sleep entry
    if (next_s.mode != PSM_SLEEP) begin
      next_s.alt_out = ALT_IN;
    end

    // clock gated right after start write
    next_s.cpu_clk_en = (next_s.mode == PSM_RUN);
    // watchdog halted in doze and sleep
    next_s.wdt_run = (next_s.mode == PSM_RUN);
    // oscillator and peripherals stop in sleep
    next_s.osc_run = (next_s.mode != PSM_SLEEP);
    next_s.periph_clk_en = (next_s.mode != PSM_SLEEP);

    case (next_s.mode)
      PSM_DOZE: begin
        next_s.ale = 1'b1;
        next_s.fetch_strobe = 1'b1;
      end
      PSM_SLEEP: begin
        next_s.ale = 1'b0;
        next_s.fetch_strobe = 1'b0;
      end
      default: begin
        next_s.ale = ALE_IN;
        next_s.fetch_strobe = FETCH_STROBE_IN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  // reset ends doze or sleep, oscillator on
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign link.ctl_rdata = s.rdata;
  assign link.in_doze = (s.mode == PSM_DOZE);
  assign link.in_sleep = (s.mode == PSM_SLEEP);
  assign PORT_SEEN = s.port_seen;
  assign ALT_OUT = s.alt_out;
  assign ALE = s.ale;
  assign PROGRAM_FETCH_STROBE = s.fetch_strobe;
  assign CPU_CLK_EN = s.cpu_clk_en;
  assign PERIPH_CLK_EN = s.periph_clk_en;
  assign WDT_RUN = s.wdt_run;
  assign OSC_RUN = s.osc_run;
  assign BAUD_DOUBLE = s.baud_dbl;
  assign GEN_FLAGS = s.gen_flags;

endmodule // psm_dev

// [logic/psm_host.sv]
// cpu side: issues arm/start sequences to the power control register
`timescale 1ns/1ps
module psm_host
  import psm_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET_N,
  psm_link_if.host link,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA
);

  typedef struct packed {
    psm_hstate_t st;
    logic op_sleep;
    logic [7:0] base;
    logic [7:0] rdata;
    logic ctl_wr;
    logic ctl_rd;
    logic [7:0] ctl_wdata;
  } psm_host_state_t;

  localparam psm_host_state_t RESET_STATE = '{
    st: PSM_H_IDLE,
    op_sleep: 1'b0,
    base: PSM_CTL_RESET,
    rdata: 8'h00,
    ctl_wr: 1'b0,
    ctl_rd: 1'b0,
    ctl_wdata: 8'h00
  };

  psm_host_state_t s;
  psm_host_state_t next_s;
  logic [7:0] arm_mask;
  logic [7:0] start_mask;
  logic halted;

  assign halted = link.in_doze || link.in_sleep;

  always_comb begin
    arm_mask = 8'h00;
    start_mask = 8'h00;
    if (s.op_sleep) begin
      arm_mask[PSM_SLEEP_ARM_POS] = 1'b1;
      start_mask[PSM_SLEEP_START_POS] = 1'b1;
    end else begin
      arm_mask[PSM_DOZE_ARM_POS] = 1'b1;
      start_mask[PSM_DOZE_START_POS] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    next_s = s;
    next_s.ctl_wr = 1'b0;
    next_s.ctl_rd = 1'b0;
    next_s.rdata = 8'h00;
    if (RD) begin
      case (ADDR)
        PSM_OFS_STATUS: begin
          next_s.rdata[PSM_ST_BUSY_POS] = (s.st != PSM_H_IDLE);
          next_s.rdata[PSM_ST_DOZE_POS] = link.in_doze;
          next_s.rdata[PSM_ST_SLEEP_POS] = link.in_sleep;
        end
        PSM_OFS_LAST: begin
          next_s.rdata = s.base;
        end
        default: begin
          next_s.rdata = 8'h00;
        end
      endcase
    end
    case (s.st)
      PSM_H_IDLE: begin
        if (WR && !halted) begin
          if (ADDR == PSM_OFS_RAW) begin
            next_s.ctl_wr = 1'b1;
            next_s.ctl_wdata = WDATA;
          end else if (ADDR == PSM_OFS_CMD && (WDATA[PSM_CMD_DOZE_POS] || WDATA[PSM_CMD_SLEEP_POS])) begin
            next_s.op_sleep = WDATA[PSM_CMD_SLEEP_POS];
            next_s.ctl_rd = 1'b1;
            next_s.st = PSM_H_READ;
          end
        end
      end
      PSM_H_READ: begin
        next_s.st = PSM_H_ARM;
      end
      PSM_H_ARM: begin
        next_s.base = link.ctl_rdata;
        next_s.ctl_wr = 1'b1;
        next_s.ctl_wdata = link.ctl_rdata | arm_mask;
        next_s.st = PSM_H_START;
      end
      PSM_H_START: begin
        next_s.ctl_wr = 1'b1;
        next_s.ctl_wdata = s.base | start_mask;
        next_s.st = PSM_H_IDLE;
      end
      default: begin
        next_s.st = PSM_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  assign link.ctl_wr = s.ctl_wr;
  assign link.ctl_rd = s.ctl_rd;
  assign link.ctl_wdata = s.ctl_wdata;
  assign RDATA = s.rdata;

endmodule // psm_host

// [tb/psm_chk.sv]
// concurrent checks on the link between cpu side and power control register
`timescale 1ns/1ps
module psm_chk (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic ctl_wr,
  input wire logic ctl_rd,
  input wire logic [7:0] ctl_wdata,
  input wire logic [7:0] ctl_rdata,
  input wire logic in_doze,
  input wire logic in_sleep
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  logic [7:0] prev;
  logic run_wr;
  assign run_wr = ctl_wr && !in_doze && !in_sleep;
  // last byte written while running
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      prev <= 8'h00;
    end else if (run_wr) begin
      prev <= ctl_wdata;
    end
  end
  ////////////////////////////////////////
  chk_doze_entry: assert property (run_wr && prev[1:0] == 2'h1 && !prev[5] && ctl_wdata[1:0] == 2'h0
    && ctl_wdata[6:5] == 2'h1 |=> in_doze) else $error("doze not entered");
  chk_doze_both: assert property (run_wr && ctl_wdata[0] && ctl_wdata[5] |=> !in_doze)
    else $error("doze entered on combined write");
  chk_doze_lone: assert property (run_wr && ctl_wdata[5] && !ctl_wdata[0] && !(prev[0] && !prev[5])
    |=> !in_doze) else $error("doze entered without arm");
  chk_sleep_entry: assert property (run_wr && prev[1] && !prev[6] && ctl_wdata[6] && !ctl_wdata[1]
    |=> in_sleep && !in_doze) else $error("sleep not entered");
  chk_sleep_both: assert property (run_wr && ctl_wdata[1] && ctl_wdata[6] |=> !in_sleep)
    else $error("sleep entered on combined write");
  chk_sleep_lone: assert property (run_wr && ctl_wdata[6] && !ctl_wdata[1] && !(prev[1] && !prev[6])
    |=> !in_sleep) else $error("sleep entered without arm");
  chk_sleep_held: assert property (in_sleep |=> in_sleep) else $error("sleep left without reset");
  chk_doze_cause: assert property ($rose(in_doze) |-> $past(run_wr) && prev[5] && !prev[0])
    else $error("doze not caused by start write");
  chk_sleep_cause: assert property ($rose(in_sleep) |-> $past(run_wr) && prev[6] && !prev[1])
    else $error("sleep not caused by start write");
  chk_read_bits: assert property ($past(ctl_rd) |-> (ctl_rdata & 8'h73) == 8'h00)
    else $error("arm or start bit read as one");
  cover property ($rose(in_doze));
  cover property ($fell(in_doze));
  cover property ($rose(in_sleep));
  // both arms then both starts: sleep wins
  cover property (run_wr && prev[1:0] == 2'h3 && ctl_wdata[6:5] == 2'h3);
endmodule // psm_chk

// [tb/psm_tb_top.sv]
// testbench for the power saving mode control block
`timescale 1ns/1ps
module psm_tb_top
  import psm_pkg::*;
;
  logic mclk = 1'h0;
  logic reset_n = 1'h0;
  logic irq = 1'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic ale_in = 1'h1;
  logic fetch_in = 1'h1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] alt_in = 8'h00;
  logic [7:0] port_pin = 8'h00;
  logic [7:0] rdata, port_seen, alt_out, d, f, a, s;
  logic [1:0] gflags;
  logic ale, pfs, cpu_en, per_en, wdt_run, osc_run, baud;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  psm_link_if link ();
  psm_dev u_psm_dev (.MCLK(mclk), .RESET_N(reset_n), .link(link.dev), .IRQ_PENDING(irq), .ALE_IN(ale_in),
    .FETCH_STROBE_IN(fetch_in), .ALT_IN(alt_in), .PORT_PIN(port_pin), .PORT_SEEN(port_seen), .ALT_OUT(alt_out),
    .ALE(ale), .PROGRAM_FETCH_STROBE(pfs), .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(per_en), .WDT_RUN(wdt_run),
    .OSC_RUN(osc_run), .BAUD_DOUBLE(baud), .GEN_FLAGS(gflags));
  psm_host u_psm_host (.MCLK(mclk), .RESET_N(reset_n), .link(link.host), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata));
  psm_chk u_psm_chk (.MCLK(mclk), .RESET_N(reset_n), .ctl_wr(link.ctl_wr), .ctl_rd(link.ctl_rd),
    .ctl_wdata(link.ctl_wdata), .ctl_rdata(link.ctl_rdata), .in_doze(link.in_doze),
    .in_sleep(link.in_sleep));
  initial begin
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors = n_errors + 1;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////
  function automatic logic [7:0] flags_of(input logic [7:0] v);
    return v & 8'h8C;
  endfunction
  // {cpu, wdt, periph, osc, ale, fetch strobe}
  function automatic logic [7:0] outs_of(input psm_mode_t m);
    case (m)
      PSM_DOZE: return 8'h0F;
      PSM_SLEEP: return 8'h00;
      default: return {2'h0, 4'hF, ale_in, fetch_in};
    endcase
  endfunction
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] ad, input logic [7:0] v);
    @(posedge mclk);
    addr <= ad;
    wdata <= v;
    wr <= w;
    rd <= !w;
    @(posedge mclk);
    wr <= 1'h0;
    rd <= 1'h0;
    #1 d = rdata;
  endtask
  // poll status, then look at the mode outputs
  task automatic mode_chk(input psm_mode_t m);
    for (int i = 0; i < 30; i++) begin
      bus(1'h0, PSM_OFS_STATUS, 8'h00);
      if (d === {5'h00, m[2:1], 1'h0}) break;
    end
    cmp("status", {5'h00, m[2:1], 1'h0}, d);
    cmp("outs", outs_of(m), {2'h0, cpu_en, wdt_run, per_en, osc_run, ale, pfs});
  endtask
  task automatic io_chk(input psm_mode_t m);
    logic [15:0] was;
    was = {port_seen, alt_out};
    @(posedge mclk);
    port_pin <= 8'($urandom);
    alt_in <= 8'($urandom);
    ale_in <= 1'($urandom);
    fetch_in <= 1'($urandom);
    repeat (4) @(posedge mclk);
    #1 cmp("port", (m == PSM_SLEEP) ? was[15:8] : port_pin, port_seen);
    cmp("alt", (m == PSM_SLEEP) ? was[7:0] : alt_in, alt_out);
    cmp("outs", outs_of(m), {2'h0, cpu_en, wdt_run, per_en, osc_run, ale, pfs});
  endtask
  task automatic do_reset();
    @(posedge mclk);
    reset_n <= 1'h0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'h1;
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(8471));
    repeat (20) @(posedge mclk);
    reset_n <= 1'h1;
    mode_chk(PSM_RUN);
    io_chk(PSM_RUN);
    bus(1'h0, 4'h9, 8'h00);
    cmp("unmapped", 8'h00, d);
    for (int k = 0; k < 2; k++) begin
      a = {6'h00, k[0], !k[0]};
      s = {1'h0, k[0], !k[0], 5'h00};
      f = 8'($urandom) & 8'h8C;
      bus(1'h1, PSM_OFS_RAW, a);
      bus(1'h1, PSM_OFS_RAW, a | s);
      bus(1'h1, PSM_OFS_RAW, s);
      bus(1'h1, PSM_OFS_RAW, a);
      bus(1'h1, PSM_OFS_RAW, f);
      bus(1'h1, PSM_OFS_RAW, s | f);
      mode_chk(PSM_RUN);
      cmp("flags", flags_of(f), {baud, 3'h0, gflags, 2'h0});
    end
    bus(1'h1, PSM_OFS_CMD, 8'h01);
    mode_chk(PSM_DOZE);
    io_chk(PSM_DOZE);
    bus(1'h0, PSM_OFS_LAST, 8'h00);
    cmp("last", flags_of(f), d);
    @(posedge mclk);
    irq <= 1'h1;
    @(posedge mclk);
    #1 cmp("doze", 8'h00, {7'h00, link.in_doze});
    irq <= 1'h0;
    mode_chk(PSM_RUN);
    bus(1'h1, PSM_OFS_CMD, 8'h01);
    mode_chk(PSM_DOZE);
    do_reset();
    mode_chk(PSM_RUN);
    cmp("flags", 8'h00, {baud, 3'h0, gflags, 2'h0});
    // sleep by command, by both command bits, and by both raw sequences at once
    for (int k = 2; k < 5; k++) begin
      if (k < 4) begin
        bus(1'h1, PSM_OFS_CMD, 8'(k));
      end else begin
        bus(1'h1, PSM_OFS_RAW, 8'h03);
        bus(1'h1, PSM_OFS_RAW, 8'h60);
      end
      mode_chk(PSM_SLEEP);
      io_chk(PSM_SLEEP);
      @(posedge mclk);
      irq <= 1'h1;
      repeat (3) @(posedge mclk);
      irq <= 1'h0;
      mode_chk(PSM_SLEEP);
      do_reset();
      mode_chk(PSM_RUN);
    end
    tally_and_finish();
  end
endmodule // psm_tb_top
